// *** shared/point_codec_if.sv ***
`timescale 1ns/1ps
interface point_codec_if;
  logic [13:0] enc_raw;   // Stored point to send
  logic [15:0] enc_code;  // Its transfer code
  logic [15:0] dec_code;  // Received transfer code
  logic [13:0] dec_raw;   // Its stored point
  logic        wide;      // Two bytes per point
  logic        positive;  // Positive integer codes
  modport user  (output enc_raw, dec_code, wide, positive, input enc_code, dec_raw);
  modport codec (input enc_raw, dec_code, wide, positive, output enc_code, dec_raw);
endinterface : point_codec_if

// *** shared/wpt_pkg.sv ***
package wpt_pkg;
  // Point, code and index widths
  localparam int PT_W       = 14;
  localparam int NINE_W     = 9;
  localparam int CODE_W     = 16;
  localparam int IDX_W      = 14;
  localparam int ADDR_W     = 16;
  localparam int LJ_PAD     = CODE_W - PT_W;
  localparam int NARROW_PAD = PT_W - 8;
  // Slots: four references plus the live record
  localparam int          SLOT_N   = 5;
  localparam logic [2:0]  ACQ_SLOT = 3'h4;
  // The two record lengths
  localparam logic [IDX_W-1:0] LEN_SHORT = 14'h01f4;
  localparam logic [IDX_W-1:0] LEN_LONG  = 14'h2710;
  localparam int MEM_DEPTH = SLOT_N * int'(LEN_LONG);
  // Output stack depth, sign plus five digits plus comma fits
  localparam int STK_D = 8;
  // Register byte offsets
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_LEN    = 12'h004;
  localparam logic [11:0] OFF_INLEN  = 12'h008;
  localparam logic [11:0] OFF_START  = 12'h00c;
  localparam logic [11:0] OFF_STOP   = 12'h010;
  localparam logic [11:0] OFF_CMD    = 12'h014;
  localparam logic [11:0] OFF_STAT   = 12'h018;
  localparam logic [11:0] OFF_PREFMT = 12'h01c;
  localparam logic [11:0] OFF_PRE    = 12'h020;
  // Field positions
  localparam int CTRL_ENC_LSB  = 0;
  localparam int CTRL_WIDE_BIT = 3;
  localparam int CTRL_SRC_LSB  = 4;
  localparam int CTRL_DST_LSB  = 8;
  localparam int CMD_SEND      = 0;
  localparam int CMD_RECV      = 1;
  localparam int CMD_ABORT     = 2;
  // Reset values
  localparam logic [9:0]       CTRL_RST  = 10'h000;
  localparam logic [IDX_W-1:0] START_RST = 14'h0001;
  localparam logic [IDX_W-1:0] STOP_RST  = LEN_LONG;
  localparam logic [3:0]       LEN_RST   = 4'h0;
  // Characters
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_NINE  = 8'h39;

  // Transfer encodings
  typedef enum logic [2:0] {
    ENC_ASCII           = 3'h0,
    SIGNED_HIGH_FIRST   = 3'h1,
    UNSIGNED_HIGH_FIRST = 3'h2,
    SIGNED_LOW_FIRST    = 3'h3,
    UNSIGNED_LOW_FIRST  = 3'h4
  } enc_type;

  // Capture modes of the live record
  typedef enum logic [1:0] {
    MODE_SAMPLE       = 2'h0,
    PEAK_CAPTURE_MODE = 2'h1,
    MODE_HULL         = 2'h2,
    AVERAGED_MODE     = 2'h3
  } acq_mode_type;

  // Sequencer states
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_FETCH = 6'h02,
    ST_LOAD  = 6'h04,
    ST_DIGIT = 6'h08,
    ST_EMIT  = 6'h10,
    ST_RECV  = 6'h20
  } state_type;

  // First memory word of a slot
  function automatic logic [ADDR_W-1:0] slot_base(input logic [2:0] s);
    return 16'(16'(s) * 16'(LEN_LONG));
  endfunction : slot_base

  // Record length from its select bit
  function automatic logic [IDX_W-1:0] rec_len(input logic long_sel);
    return long_sel ? LEN_LONG : LEN_SHORT;
  endfunction : rec_len
endpackage : wpt_pkg

// *** verif/controller_model.sv ***
`timescale 1ns/1ps
module controller_model
(
  input  wire logic       clk,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  input  wire logic       out_last,
  output logic            out_ready,
  output logic            in_valid,
  output logic [7:0]      in_data,
  output logic            in_last,
  input  wire logic       in_ready
);
  logic [7:0] rx_q [$];  // Bytes taken from the block
  logic       done;      // Final byte seen
  initial
  begin
    out_ready = 1'b0;
    in_valid  = 1'b0;
    in_data   = 8'h5a;
    in_last   = 1'b0;
    done      = 1'b0;
  end
  // Sink with random stalls
  always @(posedge clk)
  begin
    if (out_valid === 1'b1 && out_ready === 1'b1)
    begin
      rx_q.push_back(out_data);
      if (out_last === 1'b1) done = 1'b1;
    end
    out_ready <= ($urandom_range(3) != 0);
  end
  // One inbound byte, held until taken, then scrambled
  task push_byte(input logic [7:0] b, input logic l);
    @(posedge clk);
    in_valid <= 1'b1;
    in_data  <= b;
    in_last  <= l;
    do @(posedge clk); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
    in_data  <= ~b;
    in_last  <= 1'b0;
  endtask : push_byte
endmodule : controller_model

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import wpt_pkg::*;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, acq_wr = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic [13:0] acq_index = 14'h0, acq_point = 14'h0, pts [0:2], rpts [0:2];
  logic [127:0] acq_preamble = 128'h0;
  logic [1:0] acq_mode = 2'h3;
  logic pready, pslverr, out_valid, out_ready, out_last, in_valid, in_ready, in_last, ev;
  logic [7:0] out_data, in_data, exp_q [$];
  logic [15:0] c;
  int errors = 0, checks = 0;
  always #2 clk = ~clk;
  waveform_point_transfer_formatter i_waveform_point_transfer_formatter (.clk(clk),
    .rst_b(rst_b), .ce(1'b1), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .acq_wr(acq_wr),
    .acq_index(acq_index), .acq_point(acq_point), .acq_mode(acq_mode), .acq_long(1'b0),
    .acq_preamble(acq_preamble), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .out_last(out_last), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .in_last(in_last));
  controller_model i_controller_model (.clk(clk), .out_valid(out_valid), .out_data(out_data),
    .out_last(out_last), .out_ready(out_ready), .in_valid(in_valid), .in_data(in_data),
    .in_last(in_last), .in_ready(in_ready));
  // One comparison
  task cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  // APB transfer, waits for pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  // Expected bytes of one point
  task model_point(input logic [13:0] p, input logic [2:0] enc, input logic wide, input bit l);
    string s;
    c = wide ? {p, 2'h0} : {8'h00, p[13:6]};
    if (enc == 3'h0)
    begin
      s = $sformatf("%0d", wide ? int'($signed(c)) : int'($signed(c[7:0])));
      foreach (s[i]) exp_q.push_back(s[i]);
      if (!l) exp_q.push_back(CH_COMMA);
    end
    else
    begin
      if (enc == 3'h2 || enc == 3'h4) c = c ^ (wide ? 16'h8000 : 16'h0080);
      if (!wide) exp_q.push_back(c[7:0]);
      else if (enc < 3'h3) exp_q = {exp_q, c[15:8], c[7:0]};
      else exp_q = {exp_q, c[7:0], c[15:8]};
    end
  endtask : model_point
  // Send a window and compare the stream
  task xfer(input logic [31:0] ctrl, input int first, input int n, input logic [13:0] a [0:2]);
    apb(1'b1, OFF_CTRL, ctrl);
    apb(1'b1, OFF_START, 32'(first));
    apb(1'b1, OFF_STOP, 32'(first + n - 1));
    for (int k = 0; k < n; k++) model_point(a[k], ctrl[2:0], ctrl[3], k == n - 1);
    apb(1'b0, OFF_PRE, 32'h0);
    apb(1'b1, OFF_CMD, 32'h1);
    while (!i_controller_model.done) @(posedge clk);
    repeat (4) @(posedge clk);
    cmp("byte count", exp_q.size(), i_controller_model.rx_q.size());
    foreach (exp_q[i]) cmp("stream byte", exp_q[i], i_controller_model.rx_q[i]);
    exp_q = {};
    i_controller_model.rx_q = {};
    i_controller_model.done = 1'b0;
    $display("test send ctrl %h done", ctrl);
  endtask : xfer
  task tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // Hang guard
  initial
  begin
    repeat (30000) @(posedge clk);
    errors++;
    tally_and_finish;
  end
  // Main sequence
  initial
  begin
    void'($urandom(32'h28ec));
    acq_preamble <= {$urandom, $urandom, $urandom, $urandom};
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, OFF_START, 32'h0);
    cmp("start reset", 32'(START_RST), rv);
    apb(1'b0, OFF_STOP, 32'h0);
    cmp("stop reset", 32'(STOP_RST), rv);
    apb(1'b0, 12'h100, 32'h0);
    cmp("unmapped err", 32'h1, 32'(ev));
    cmp("unmapped data", 32'h0, rv);
    $display("test registers done");
    for (int k = 0; k < 3; k++)
    begin
      pts[k] = 14'($urandom);
      rpts[k] = 14'($urandom);
      @(posedge clk);
      {acq_wr, acq_index, acq_point} <= {1'b1, 14'(k), pts[k]};
      acq_mode <= (k == 1) ? 2'h1 : 2'h3;
      if (k == 1) pts[k][4:0] = 5'h00;
      @(posedge clk);
      acq_wr <= 1'b0;
    end
    for (int e = 0; e < 5; e++)
      for (int w = 0; w < 2; w++) xfer(32'h40 | 32'(e) | 32'(w << 3), 1, 3, pts);
    apb(1'b0, OFF_PRE, 32'h0);
    cmp("live preamble", acq_preamble[31:0], rv);
    apb(1'b1, OFF_CTRL, 32'h149);
    apb(1'b1, OFF_INLEN, 32'h0);
    apb(1'b1, OFF_START, 32'h2);
    apb(1'b1, OFF_PRE, {rpts[2], rpts[1], 4'h0});
    apb(1'b1, OFF_CMD, 32'h2);
    for (int k = 0; k < 2; k++)
    begin
      i_controller_model.push_byte({rpts[k][13:6]}, 1'b0);
      i_controller_model.push_byte({rpts[k][5:0], 2'h0}, k == 1);
    end
    repeat (4) @(posedge clk);
    $display("test receive done");
    xfer(32'h19, 2, 2, rpts);
    apb(1'b0, OFF_PRE, 32'h0);
    cmp("slot preamble", {rpts[2], rpts[1], 4'h0}, rv);
    tally_and_finish;
  end
endmodule : testbench
bind waveform_point_transfer_formatter wpt_checker i_wpt_checker (.clk(clk), .rst_b(rst_b),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .paddr(paddr), .prdata(prdata), .acq_wr(acq_wr), .acq_index(acq_index),
  .out_valid(out_valid), .out_ready(out_ready), .out_last(out_last), .out_data(out_data),
  .in_valid(in_valid), .in_ready(in_ready), .in_last(in_last));

// *** verif/wpt_checker.sv ***
`timescale 1ns/1ps
module wpt_checker
(
  input logic        clk,
  input logic        rst_b,
  input logic        ce,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic        pready,
  input logic        pslverr,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic        acq_wr,
  input logic [13:0] acq_index,
  input logic        out_valid,
  input logic        out_ready,
  input logic        out_last,
  input logic [7:0]  out_data,
  input logic        in_valid,
  input logic        in_ready,
  input logic        in_last
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Access phase of an APB transfer, clock enabled
  wire acc = psel && penable && ce;
  pready_comb_a: assert property (pready == acc) else $error("pready differs from access");
  err_setup_a: assert property (!acc |-> !pslverr) else $error("pslverr outside access");
  unmapped_err_a: assert property (acc && paddr >= 12'h030 |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && paddr <= 12'h02c && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data)
    && $stable(out_last)) else $error("outbound byte dropped while stalled");
  acq_block_a: assert property (acq_wr && acq_index < 14'h2710 |-> !in_ready)
    else $error("inbound accepted during capture write");
  reset_quiet_a: assert property (disable iff (1'b0) !rst_b ##1 !rst_b
    |-> !out_valid && !in_ready) else $error("streams active in reset");
  last_idle_a: assert property (out_valid && out_ready && out_last |=> !out_valid [*2])
    else $error("bytes after final point");
  // Main scenarios
  send_done_c: cover property (out_valid && out_ready && out_last);
  recv_done_c: cover property (in_valid && in_ready && in_last);
  refused_c: cover property (acc && pslverr);
endmodule : wpt_checker

// *** verilog/point_codec.sv ***
`timescale 1ns/1ps
module point_codec
  import wpt_pkg::*;
(
  point_codec_if.codec pc
);
  logic [15:0] flip_mask;  // Offset of half the code range
  logic [15:0] dec_flip;   // Received code back to signed

  // Half range flips the top bit of the chosen width
  assign flip_mask = pc.wide ? {pc.positive, 15'h0000} : {8'h00, pc.positive, 7'h00};

  // Wide: left justify; narrow: keep top eight bits
  assign pc.enc_code = (pc.wide ? {pc.enc_raw, {LJ_PAD{1'b0}}}
                                : {{8{pc.enc_raw[PT_W-1]}}, pc.enc_raw[PT_W-1 -: 8]})
                       ^ flip_mask;

  // Inverse for inbound codes
  assign dec_flip   = pc.dec_code ^ flip_mask;
  assign pc.dec_raw = pc.wide ? dec_flip[CODE_W-1:LJ_PAD] : {dec_flip[7:0], {NARROW_PAD{1'b0}}};
endmodule : point_codec

// *** verilog/waveform_point_transfer_formatter.sv ***
// What this block does
// - keep 9-bit points, averaged up to 14
// - peak and hull values are min/max members
// - two-byte points left-justified in sixteen bits
// - one-byte points keep top eight bits
// - ASCII values signed within the width range
// - ASCII digits, minus sign, commas between points
// - binary signed or positive integer ranges
// - four binary formats, high or low first
// - one-byte width ignores byte order
// - record length is 500 or 10000
// - send points first through last, from one
// - store inbound points from first index
// - inbound ignores last index, stops at length
// - one inbound waveform into selected slot
// - each waveform carries its preamble
`timescale 1ns/1ps
module waveform_point_transfer_formatter
  import wpt_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  input  wire logic [11:0]  paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         acq_wr,
  input  wire logic [13:0]  acq_index,
  input  wire logic [13:0]  acq_point,
  input  wire logic [1:0]   acq_mode,
  input  wire logic         acq_long,
  input  wire logic [127:0] acq_preamble,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [7:0]   out_data,
  output logic              out_last,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [7:0]   in_data,
  input  wire logic         in_last
);
  point_codec_if pc ();                 // Link to the codec
  logic [1:0]        rst_q;             // Reset release chain
  logic              rst_sync_b;        // Released reset
  logic [9:0]        ctrl_q;            // Encoding, width, slots
  logic [IDX_W-1:0]  start_q;           // First point, from one
  logic [IDX_W-1:0]  stop_q;            // Last point, from one
  logic [3:0]        len_q;             // Per slot long length
  logic [31:0]       pre_q [0:15];      // Preambles of four slots
  logic [31:0]       prdata_q;          // Read data
  logic              pslverr_q;         // Unmapped access
  logic [13:0]       pts [0:MEM_DEPTH-1]; // Point memory
  logic [13:0]       rd_q;              // Fetched point
  state_type         state_q;           // Sequencer
  logic [IDX_W-1:0]  idx_q;             // Current point, from zero
  logic [IDX_W-1:0]  last_q;            // Final index
  logic [7:0]        stk_q [0:STK_D-1]; // Byte stack, top first
  logic [3:0]        cnt_q;             // Bytes on stack
  logic [15:0]       mag_q;             // Magnitude being split
  logic [15:0]       acc_q;             // Inbound accumulator
  logic              neg_q;             // Value is negative
  logic              dd_q;              // Digits done
  logic              half_q;            // First of two bytes held
  logic              have_q;            // Digit seen
  // Decoded settings
  wire enc_type      enc      = enc_type'(ctrl_q[CTRL_ENC_LSB +: 3]);
  wire               wide     = ctrl_q[CTRL_WIDE_BIT];
  wire [2:0]         src      = ctrl_q[CTRL_SRC_LSB +: 3];
  wire [1:0]         dst      = ctrl_q[CTRL_DST_LSB +: 2];
  wire               positive = (enc == UNSIGNED_HIGH_FIRST) | (enc == UNSIGNED_LOW_FIRST);
  wire               signd    = (enc == SIGNED_HIGH_FIRST) | (enc == SIGNED_LOW_FIRST);
  wire               low_first = (enc == SIGNED_LOW_FIRST) | (enc == UNSIGNED_LOW_FIRST);
  wire               ascii    = ~(positive | signd);
  wire               src_long = (src == ACQ_SLOT) ? acq_long : len_q[src[1:0]];
  wire               idle     = (state_q == ST_IDLE);
  // Window arithmetic
  wire [IDX_W-1:0]   s_len    = rec_len(src_long);
  wire [IDX_W-1:0]   d_len    = rec_len(len_q[dst]);
  wire [IDX_W-1:0]   s_end    = (stop_q == 14'h0000 || stop_q > s_len) ? s_len : stop_q;
  wire [IDX_W-1:0]   first_ix = (start_q == 14'h0000) ? 14'h0000 : start_q - 14'h0001;
  wire               send_ok  = first_ix < s_end;
  wire               recv_ok  = first_ix < d_len;
  // Bus decode
  wire               setup    = psel & ~penable;
  wire               wr_acc   = psel & penable & pwrite & ce;
  wire               hit_ctrl = (paddr == OFF_CTRL);
  wire               hit_len  = (paddr == OFF_LEN);
  wire               hit_inl  = (paddr == OFF_INLEN);
  wire               hit_strt = (paddr == OFF_START);
  wire               hit_stop = (paddr == OFF_STOP);
  wire               hit_cmd  = (paddr == OFF_CMD);
  wire               hit_stat = (paddr == OFF_STAT);
  wire               hit_pfmt = (paddr == OFF_PREFMT);
  wire               hit_pre  = (paddr[11:4] == OFF_PRE[11:4]);
  wire [1:0]         pword    = paddr[3:2];
  wire               mapped   = hit_ctrl | hit_len | hit_inl | hit_strt | hit_stop
                              | hit_cmd | hit_stat | hit_pfmt | hit_pre;
  wire               cfg_wr   = wr_acc & idle;
  wire               cmd_wr   = wr_acc & hit_cmd;
  wire               send_go  = cmd_wr & pwdata[CMD_SEND] & idle & send_ok;
  wire               recv_go  = cmd_wr & pwdata[CMD_RECV] & ~pwdata[CMD_SEND] & idle & recv_ok;
  wire               abort    = cmd_wr & pwdata[CMD_ABORT];
  wire [31:0]        pre_rd   = (src == ACQ_SLOT) ? acq_preamble[32*pword +: 32]
                                                  : pre_q[{src[1:0], pword}];
  wire [31:0]        rd_d;
  // Send path
  wire [15:0]        code     = pc.enc_code;
  wire               at_last  = (idx_q == last_q);
  wire               in_load  = (state_q == ST_LOAD);
  wire               in_digit = (state_q == ST_DIGIT);
  wire               pair_en  = in_load & ~ascii & wide;
  wire               push_en  = (in_load & (ascii ? ~at_last : ~wide)) | (in_digit & (~dd_q | neg_q));
  wire [7:0]         digit    = CH_ZERO + 8'(mag_q % 16'd10);
  wire [7:0]         push_val = in_load ? (ascii ? CH_COMMA : code[7:0]) : (dd_q ? CH_MINUS : digit);
  wire               pop_en   = out_valid & out_ready;
  wire [15:0]        neg_code = 16'(-code);
  // Receive path
  wire               take     = in_valid & in_ready;
  wire               is_dig   = (in_data >= CH_ZERO) & (in_data <= CH_NINE);
  wire [15:0]        asc_acc  = is_dig ? 16'(acc_q * 16'd10 + {12'h000, in_data[3:0]}) : acc_q;
  wire [15:0]        asc_val  = neg_q ? 16'(-asc_acc) : asc_acc;
  wire [15:0]        bin_code = ~wide ? {8'h00, in_data}
                              : (low_first ? {in_data, acc_q[7:0]} : {acc_q[15:8], in_data});
  wire               rx_pt    = take & (ascii ? ((in_data == CH_COMMA | in_last) & (have_q | is_dig))
                                              : (~wide | half_q));
  // Memory write port, live capture has priority
  wire               acq_ok   = acq_wr & (acq_index < LEN_LONG);
  wire               mem_we   = acq_ok | rx_pt;
  wire [ADDR_W-1:0]  wr_addr  = acq_ok ? slot_base(ACQ_SLOT) + 16'(acq_index)
                                       : slot_base({1'b0, dst}) + 16'(idx_q);
  wire [13:0]        acq_kept = (acq_mode == AVERAGED_MODE) ? acq_point
                                : {acq_point[PT_W-1 -: NINE_W], {(PT_W-NINE_W){1'b0}}};
  wire [ADDR_W-1:0]  rd_addr  = slot_base(src) + 16'(idx_q);

  // Codec hookup
  assign pc.enc_raw  = rd_q;
  assign pc.dec_code = ascii ? asc_val : bin_code;
  assign pc.wide     = wide;
  assign pc.positive = positive;
  point_codec u_codec (.pc(pc));

  // Register read selection
  assign rd_d = hit_ctrl ? {22'h000000, ctrl_q}
              : hit_len  ? {27'h0000000, acq_long, len_q}
              : hit_inl  ? {31'h00000000, len_q[dst]}
              : hit_strt ? {18'h00000, start_q}
              : hit_stop ? {18'h00000, stop_q}
              : hit_stat ? {12'h000, state_q, idx_q}
              : hit_pfmt ? {27'h0000000, src_long, ctrl_q[3:0]}
              : hit_pre  ? pre_rd
              : 32'h00000000;

  // Bus outputs
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q & pready;
  assign pready  = ce & psel & penable;   // No answer while frozen

  // Stream handshakes
  assign out_valid = ce & (state_q == ST_EMIT) & (cnt_q != 4'h0);
  assign out_data  = stk_q[0];
  assign out_last  = out_valid & (cnt_q == 4'h1) & at_last;
  assign in_ready  = ce & (state_q == ST_RECV) & ~acq_ok;

  // Reset release chain
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b) rst_q <= 2'b00;
    else        rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_sync_b = rst_q[1];

  // Read data captured in the setup phase
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else if (ce && setup)
    begin
      prdata_q  <= pwrite ? 32'h00000000 : rd_d;
      pslverr_q <= ~mapped;
    end
  end

  // Settings, refused while a transfer runs
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      ctrl_q  <= CTRL_RST;
      start_q <= START_RST;
      stop_q  <= STOP_RST;
      len_q   <= LEN_RST;
    end
    else if (cfg_wr)
    begin
      if (hit_ctrl)      ctrl_q  <= pwdata[9:0];
      else if (hit_strt) start_q <= pwdata[IDX_W-1:0];
      else if (hit_stop) stop_q  <= pwdata[IDX_W-1:0];
      else if (hit_len)  len_q   <= pwdata[3:0];
      else if (hit_inl)  len_q[dst] <= pwdata[0];
    end
  end

  // Preamble store of the destination slot
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      for (int i = 0; i < 16; i++) pre_q[i] <= 32'h00000000;
    end
    else if (cfg_wr && hit_pre)
    begin
      pre_q[{dst, pword}] <= pwdata;
    end
  end

  // Point memory, one read and one write port
  always_ff @(posedge clk)
  begin
    if (ce && mem_we)
      // Peak and hull captures arrive as min/max pairs
      pts[wr_addr] <= acq_ok ? acq_kept : pc.dec_raw;
    if (ce)
      rd_q <= pts[rd_addr];
  end

  // Byte stack, shifts down on push and up on pop
  for (genvar gi = 0; gi < STK_D; gi++)
  begin : g_stk
    logic [7:0] above;  // Entry pushed into this place
    logic [7:0] below;  // Entry popped into this place
    if (gi == 0) assign above = push_val;
    else         assign above = stk_q[gi-1];
    if (gi == STK_D-1) assign below = 8'h00;
    else               assign below = stk_q[gi+1];
    always_ff @(posedge clk or negedge rst_sync_b)
    begin
      if (!rst_sync_b)   stk_q[gi] <= 8'h00;
      else if (ce)
      begin
        if (pair_en)     stk_q[gi] <= (gi == 0) ? (low_first ? code[7:0] : code[15:8])
                                     : (gi == 1) ? (low_first ? code[15:8] : code[7:0])
                                     : 8'h00;
        else if (push_en) stk_q[gi] <= above;
        else if (pop_en)  stk_q[gi] <= below;
      end
    end
  end

  // Stack fill count
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)     cnt_q <= 4'h0;
    else if (ce)
    begin
      if (abort)         cnt_q <= 4'h0;
      else if (pair_en)  cnt_q <= 4'h2;
      else if (push_en)  cnt_q <= cnt_q + 4'h1;
      else if (pop_en)   cnt_q <= cnt_q - 4'h1;
    end
  end

  // Sequencer
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      state_q <= ST_IDLE;
      idx_q   <= 14'h0000;
      last_q  <= 14'h0000;
      mag_q   <= 16'h0000;
      acc_q   <= 16'h0000;
      neg_q   <= 1'b0;
      dd_q    <= 1'b0;
      half_q  <= 1'b0;
      have_q  <= 1'b0;
    end
    else if (ce)
    begin
      if (abort) state_q <= ST_IDLE;
      else
        case (state_q)
          ST_IDLE:
          begin
            // Window set up for either direction
            idx_q  <= first_ix;
            last_q <= send_go ? s_end - 14'h0001 : d_len - 14'h0001;
            acc_q  <= 16'h0000;
            neg_q  <= 1'b0;
            half_q <= 1'b0;
            have_q <= 1'b0;
            if (send_go)      state_q <= ST_FETCH;
            else if (recv_go) state_q <= ST_RECV;
          end
          ST_FETCH: state_q <= ST_LOAD;                    // Memory read latency
          ST_LOAD:
          begin
            // ASCII is always signed; split magnitude next
            neg_q   <= code[15];
            mag_q   <= code[15] ? neg_code : code;
            dd_q    <= 1'b0;
            state_q <= ascii ? ST_DIGIT : ST_EMIT;
          end
          ST_DIGIT:
          begin
            // Digits least first, then minus sign
            if (!dd_q)
            begin
              mag_q <= mag_q / 16'd10;
              if (mag_q < 16'd10) dd_q <= 1'b1;
            end
            else state_q <= ST_EMIT;
          end
          ST_EMIT:
          begin
            // Next point once its last byte leaves
            if (pop_en && cnt_q == 4'h1)
            begin
              if (at_last) state_q <= ST_IDLE;
              else
              begin
                idx_q   <= idx_q + 14'h0001;
                state_q <= ST_FETCH;
              end
            end
          end
          ST_RECV:
          begin
            if (rx_pt)
            begin
              // Point stored, stop at length or end of data
              idx_q  <= idx_q + 14'h0001;
              acc_q  <= 16'h0000;
              neg_q  <= 1'b0;
              half_q <= 1'b0;
              have_q <= 1'b0;
              if (at_last || in_last) state_q <= ST_IDLE;
            end
            else if (take)
            begin
              if (in_last)                    state_q <= ST_IDLE;
              else if (!ascii)
              begin
                half_q <= 1'b1;
                acc_q  <= {in_data, in_data};
              end
              else if (is_dig)
              begin
                acc_q  <= asc_acc;
                have_q <= 1'b1;
              end
              else if (in_data == CH_MINUS)   neg_q <= 1'b1;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
    end
  end
endmodule : waveform_point_transfer_formatter
